// >>> hdl/csdb_pkg.sv
// Package: register map, field layouts and bus response codes of the clock select bank
package csdb_pkg;

  localparam int CSDB_AW   = 12;
  localparam int CSDB_DW   = 32;
  localparam int CSDB_HW   = 16;
  localparam int CSDB_NREG = 11;

  localparam logic [1:0] CSDB_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CSDB_RESP_SLVERR = 2'h2;

  // Register indices into the bank
  localparam int CSDB_I_SERIAL = 0;
  localparam int CSDB_I_CAMMEM = 1;
  localparam int CSDB_I_DISP0  = 2;
  localparam int CSDB_I_DPAHB  = 3;
  localparam int CSDB_I_DISP1  = 4;
  localparam int CSDB_I_ROT    = 5;
  localparam int CSDB_I_VAXI   = 6;
  localparam int CSDB_I_CODEC  = 7;
  localparam int CSDB_I_APB    = 8;
  localparam int CSDB_I_SDGPU  = 9;
  localparam int CSDB_I_TS     = 10;

  // Byte offsets: serial_port_clock_select, camera_crypto_memclk_select .. transport
  localparam logic [CSDB_AW-1:0] CSDB_OFF [CSDB_NREG] = '{
    12'h0C4, 12'h0C8, 12'h0CC, 12'h0D0, 12'h0D4, 12'h0D8,
    12'h0DC, 12'h0E0, 12'h0E4, 12'h0E8, 12'h0EC};

  // Bits that software may change; all others are reserved and read zero
  localparam logic [CSDB_HW-1:0] CSDB_RW [CSDB_NREG] = '{
    16'hFFFF, 16'hBFC7, 16'hFF03, 16'h9FFF, 16'hFFDF, 16'hDFDF,
    16'hDFDF, 16'hDFDF, 16'h1F1F, 16'hFFDF, 16'hDFDF};

  localparam logic [CSDB_HW-1:0] CSDB_RST [CSDB_NREG] = '{
    16'h0707, 16'h0EC0, 16'h0700, 16'h0F03, 16'h0742, 16'h0000,
    16'h0000, 16'h0101, 16'h0303, 16'h8000, 16'h0303};

  typedef struct packed {
    logic       serial_port1_source;
    logic [6:0] serial_port1_divider;
    logic       serial_port0_source;
    logic [6:0] serial_port0_divider;
  } csdb_serial_t;

  typedef struct packed {
    logic       cam_out_ref24;
    logic       rsvd14;
    logic [4:0] cam_divider;
    logic       cam_source;
    logic [1:0] crypto_divider;
    logic [2:0] rsvd5_3;
    logic       mem_source;
    logic [1:0] mem_phy_ratio;
  } csdb_cammem_t;

  typedef struct packed {
    logic [7:0] display0_divider;
    logic [5:0] rsvd7_2;
    logic [1:0] display0_source;
  } csdb_disp0_t;

  typedef struct packed {
    logic       displayport_ref_choice;
    logic [1:0] rsvd14_13;
    logic [4:0] video_ahb_divider;
    logic [1:0] dp_source;
    logic [5:0] dp_divider;
  } csdb_dpahb_t;

  typedef struct packed {
    logic [7:0] display1_divider;
    logic [1:0] display1_source;
    logic       rsvd5;
    logic       cam_in_invert;
    logic       isp_in_invert;
    logic       spare2;
    logic [1:0] spare1_0;
  } csdb_disp1_t;

  // Shared layout: two sources at 15:14 and 7:6, two dividers at 12:8 and 4:0
  typedef struct packed {
    logic [1:0] hi_source;
    logic       rsvd13;
    logic [4:0] hi_divider;
    logic [1:0] lo_source;
    logic       rsvd5;
    logic [4:0] lo_divider;
  } csdb_pair_t;

  typedef struct packed {
    logic [2:0] rsvd15_13;
    logic [4:0] alive_divider;
    logic [2:0] rsvd7_5;
    logic [4:0] power_divider;
  } csdb_apb_t;

  typedef struct packed {
    logic [1:0] second_card_source;
    logic [5:0] second_card_divider;
    logic [1:0] gpu_source;
    logic       rsvd5;
    logic [4:0] gpu_divider;
  } csdb_sdgpu_t;

  typedef struct packed {
    csdb_serial_t serial;
    csdb_cammem_t cammem;
    csdb_disp0_t  disp0;
    csdb_dpahb_t  dpahb;
    csdb_disp1_t  disp1;
    csdb_pair_t   rotation;
    csdb_pair_t   video_axi;
    csdb_pair_t   codec_axi;
    csdb_apb_t    apb;
    csdb_sdgpu_t  sdgpu;
    csdb_pair_t   tstream;
  } csdb_cfg_t;

endpackage

// >>> hdl/csdb_mreg.sv
// Masked-write 16-bit configuration register with reserved bits held at zero
`timescale 1ns/1ps
module csdb_mreg
  import csdb_pkg::*;
#(
  parameter logic [CSDB_HW-1:0] RW_BITS = 16'hFFFF,
  parameter logic [CSDB_HW-1:0] RST_VAL = 16'h0000
)(
  input  wire logic               core_clk,
  input  wire logic               nrst,
  input  wire logic               wr_en,
  input  wire logic [CSDB_HW-1:0] wr_data,
  input  wire logic [CSDB_HW-1:0] wr_mask,
  output logic      [CSDB_HW-1:0] val_q
);

  logic [CSDB_HW-1:0] bit_en;
  logic [CSDB_HW-1:0] val_d;

  // Reserved bits never open, whatever the mask says
  assign bit_en = wr_mask & RW_BITS;
  assign val_d  = (val_q & ~bit_en) | (wr_data & bit_en);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      val_q <= RST_VAL & RW_BITS;
    else if (wr_en)
      val_q <= val_d;
  end

endmodule // csdb_mreg

// >>> hdl/csdb_bank.sv
// Clock source select and divider register bank behind an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module csdb_bank
  import csdb_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               nrst,
  input  wire logic [CSDB_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]         s_axi_awprot,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [CSDB_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [CSDB_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]         s_axi_arprot,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [CSDB_DW-1:0]      s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output csdb_cfg_t               clk_cfg
);

  typedef enum logic [1:0] {
    CSDB_WR_COLLECT = 2'b01,
    CSDB_WR_RESP    = 2'b10
  } csdb_wr_state_t;

  typedef enum logic [1:0] {
    CSDB_RD_IDLE = 2'b01,
    CSDB_RD_DATA = 2'b10
  } csdb_rd_state_t;

  // One-hot select of the register at a byte address; hit low means unmapped
  function automatic logic [CSDB_NREG-1:0] csdb_hit(input logic [CSDB_AW-1:0] addr);
    logic [CSDB_NREG-1:0] sel;
    sel = '0;
    for (int i = 0; i < CSDB_NREG; i++)
      sel[i] = (addr == CSDB_OFF[i]);
    return sel;
  endfunction

  // Byte strobes gate both the data lanes and the matching mask lanes
  function automatic logic [CSDB_HW-1:0] csdb_lane(input logic [1:0] strb);
    return {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

  csdb_wr_state_t       wr_state_q;
  csdb_wr_state_t       wr_state_d;
  csdb_rd_state_t       rd_state_q;
  csdb_rd_state_t       rd_state_d;

  logic                 aw_have_q;
  logic                 aw_have_d;
  logic                 w_have_q;
  logic                 w_have_d;
  logic [CSDB_AW-1:0]   aw_addr_q;
  logic [CSDB_DW-1:0]   w_data_q;
  logic [3:0]           w_strb_q;
  logic                 awready_q;
  logic                 awready_d;
  logic                 wready_q;
  logic                 wready_d;
  logic                 bvalid_q;
  logic [1:0]           bresp_q;
  logic                 arready_q;
  logic                 rvalid_q;
  logic [CSDB_DW-1:0]   rdata_q;
  logic [1:0]           rresp_q;

  logic                 aw_take;
  logic                 w_take;
  logic                 ar_take;
  logic                 wr_go;
  logic [CSDB_NREG-1:0] wr_sel;
  logic [CSDB_NREG-1:0] rd_sel;
  logic                 wr_hit;
  logic                 rd_hit;
  logic [CSDB_HW-1:0]   wr_mask;
  logic [CSDB_HW-1:0]   wr_lo;
  logic [CSDB_HW-1:0]   rd_word;
  logic [CSDB_HW-1:0]   reg_q [CSDB_NREG];

  assign aw_take = s_axi_awvalid & awready_q;
  assign w_take  = s_axi_wvalid & wready_q;
  assign ar_take = s_axi_arvalid & arready_q;

  // Address and data may arrive in either order; write once both are held
  assign wr_go   = aw_have_q & w_have_q;

  assign aw_have_d = (aw_have_q | aw_take) & ~wr_go;
  assign w_have_d  = (w_have_q | w_take) & ~wr_go;

  // Stay closed while a response is pending so only one write is in flight
  assign awready_d = ~aw_have_d & (wr_state_d == CSDB_WR_COLLECT);
  assign wready_d  = ~w_have_d & (wr_state_d == CSDB_WR_COLLECT);

  assign wr_sel  = csdb_hit(aw_addr_q);
  assign wr_hit  = |wr_sel;
  assign wr_lo   = w_data_q[CSDB_HW-1:0] & csdb_lane(w_strb_q[1:0]);
  assign wr_mask = w_data_q[CSDB_DW-1:CSDB_HW] & csdb_lane(w_strb_q[3:2])
                   & csdb_lane(w_strb_q[1:0]);

  assign rd_sel = csdb_hit(s_axi_araddr);
  assign rd_hit = |rd_sel;

  always_comb
  begin
    rd_word = '0;
    for (int i = 0; i < CSDB_NREG; i++)
      if (rd_sel[i])
        rd_word = reg_q[i];
  end

  always_comb
  begin
    wr_state_d = wr_state_q;
    unique case (wr_state_q)
      CSDB_WR_COLLECT:
        if (wr_go)
          wr_state_d = CSDB_WR_RESP;
      CSDB_WR_RESP:
        if (s_axi_bready)
          wr_state_d = CSDB_WR_COLLECT;
      default:
        wr_state_d = CSDB_WR_COLLECT;
    endcase
  end

  always_comb
  begin
    rd_state_d = rd_state_q;
    unique case (rd_state_q)
      CSDB_RD_IDLE:
        if (ar_take)
          rd_state_d = CSDB_RD_DATA;
      CSDB_RD_DATA:
        if (s_axi_rready)
          rd_state_d = CSDB_RD_IDLE;
      default:
        rd_state_d = CSDB_RD_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_state_q <= CSDB_WR_COLLECT;
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
    end
    else
    begin
      wr_state_q <= wr_state_d;
      aw_have_q  <= aw_have_d;
      w_have_q   <= w_have_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      aw_addr_q <= '0;
    else if (aw_take)
      aw_addr_q <= s_axi_awaddr;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else if (w_take)
    begin
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
  end

  // Unmapped writes are dropped and answered with a slave error
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= CSDB_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? CSDB_RESP_OKAY : CSDB_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  // Mask half is write-only and returns zero on reads
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_state_q <= CSDB_RD_IDLE;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= '0;
      rresp_q    <= CSDB_RESP_OKAY;
    end
    else
    begin
      rd_state_q <= rd_state_d;
      arready_q  <= (rd_state_d == CSDB_RD_IDLE);
      rvalid_q   <= (rd_state_d == CSDB_RD_DATA);
      if (ar_take)
      begin
        rdata_q <= {{CSDB_HW{1'b0}}, rd_word};
        rresp_q <= rd_hit ? CSDB_RESP_OKAY : CSDB_RESP_SLVERR;
      end
    end
  end

  for (genvar g = 0; g < CSDB_NREG; g++)
  begin : g_reg
    csdb_mreg #(
      .RW_BITS (CSDB_RW[g]),
      .RST_VAL (CSDB_RST[g])
    ) u_reg (
      .core_clk (core_clk),
      .nrst     (nrst),
      .wr_en    (wr_go & wr_sel[g]),
      .wr_data  (wr_lo),
      .wr_mask  (wr_mask),
      .val_q    (reg_q[g])
    );
  end

  // Field views straight off the register flops; drive the clock muxes
  assign clk_cfg.serial    = csdb_serial_t'(reg_q[CSDB_I_SERIAL]);
  assign clk_cfg.cammem    = csdb_cammem_t'(reg_q[CSDB_I_CAMMEM]);
  assign clk_cfg.disp0     = csdb_disp0_t'(reg_q[CSDB_I_DISP0]);
  assign clk_cfg.dpahb     = csdb_dpahb_t'(reg_q[CSDB_I_DPAHB]);
  assign clk_cfg.disp1     = csdb_disp1_t'(reg_q[CSDB_I_DISP1]);
  assign clk_cfg.rotation  = csdb_pair_t'(reg_q[CSDB_I_ROT]);
  assign clk_cfg.video_axi = csdb_pair_t'(reg_q[CSDB_I_VAXI]);
  assign clk_cfg.codec_axi = csdb_pair_t'(reg_q[CSDB_I_CODEC]);
  assign clk_cfg.apb       = csdb_apb_t'(reg_q[CSDB_I_APB]);
  assign clk_cfg.sdgpu     = csdb_sdgpu_t'(reg_q[CSDB_I_SDGPU]);
  assign clk_cfg.tstream   = csdb_pair_t'(reg_q[CSDB_I_TS]);

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule // csdb_bank

// >>> tb/csdb_bank_properties.sv
// Concurrent checks on the clock select bank bus and configuration ports
`timescale 1ns/1ps
module csdb_bank_chk
  import csdb_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               nrst,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [CSDB_DW-1:0] s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire csdb_cfg_t          clk_cfg
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");

  property p_aw_block;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("second write taken");

  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");

  property p_aw_reopen;
    s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready;
  endproperty
  a_aw_reopen: assert property (p_aw_reopen) else $error("write ready not back");

  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");

  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");

  property p_r_upper;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_r_upper: assert property (p_r_upper) else $error("mask half read nonzero");

  property p_cfg_write;
    !$stable(clk_cfg) |-> $rose(s_axi_bvalid);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config moved alone");

  property p_rsvd;
    clk_cfg.cammem.rsvd5_3 == 3'h0 && clk_cfg.disp0.rsvd7_2 == 6'h00
      && clk_cfg.apb.rsvd15_13 == 3'h0 && clk_cfg.rotation.rsvd13 == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
endmodule // csdb_bank_chk

bind csdb_bank csdb_bank_chk u_chk (.*);

// >>> tb/csdb_bank_tb_top.sv
// Self-checking bench for the clock select bank register interface
`timescale 1ns/1ps
module csdb_bank_tb_top
  import csdb_pkg::*;
;
  logic               core_clk = 1'b0;
  logic               nrst = 1'b0;
  logic [CSDB_AW-1:0] s_axi_awaddr = 12'h000;
  logic [2:0]         s_axi_awprot = 3'h0;
  logic               s_axi_awvalid = 1'b0;
  logic               s_axi_awready;
  logic [CSDB_DW-1:0] s_axi_wdata = 32'h0;
  logic [3:0]         s_axi_wstrb = 4'hF;
  logic               s_axi_wvalid = 1'b0;
  logic               s_axi_wready;
  logic [1:0]         s_axi_bresp;
  logic               s_axi_bvalid;
  logic               s_axi_bready = 1'b0;
  logic [CSDB_AW-1:0] s_axi_araddr = 12'h000;
  logic [2:0]         s_axi_arprot = 3'h0;
  logic               s_axi_arvalid = 1'b0;
  logic               s_axi_arready;
  logic [CSDB_DW-1:0] s_axi_rdata;
  logic [1:0]         s_axi_rresp;
  logic               s_axi_rvalid;
  logic               s_axi_rready = 1'b0;
  csdb_cfg_t          clk_cfg;
  csdb_cfg_t          snap;
  int                 errors = 0;
  int                 checks_done = 0;
  logic [1:0]         rsp;
  logic [31:0]        dat;
  localparam logic [15:0] RST_EXP [11] = '{16'h0707, 16'h0EC0, 16'h0700, 16'h0F03,
    16'h0742, 16'h0000, 16'h0000, 16'h0101, 16'h0303, 16'h8000, 16'h0303};
  localparam logic [15:0] RW_EXP [11] = '{16'hFFFF, 16'hBFC7, 16'hFF03, 16'h9FFF,
    16'hFFDF, 16'hDFDF, 16'hDFDF, 16'hDFDF, 16'h1F1F, 16'hFFDF, 16'hDFDF};
  localparam logic [31:0] WD [4] = '{32'hFFFFFFFF, 32'h0, 32'h00F00000, 32'hFFFF0000};

  always #5 core_clk = ~core_clk;

  csdb_bank dut (.*);

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
      $display("wrong value %s expected %h seen %h", nm, e, g);
    if (g !== e)
      errors++;
  endtask

  // Starts one edge on, so no signal is driven twice in one time step
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h1;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 40)
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        n = 99;
      end
    end
    if (n == 40)
    begin
      errors++;
      summarize();
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h1;
    d = 32'h0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 40)
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        n = 99;
      end
    end
    if (n == 40)
    begin
      errors++;
      summarize();
    end
  endtask

  task automatic t_reset();
    for (int i = 0; i < 11; i++)
    begin
      rd(12'h0C4 + 12'(i * 4), dat, rsp);
      chk("reset read", {16'h0, RST_EXP[i]}, dat);
      chk("reset cfg", {16'h0, RST_EXP[i]}, {16'h0, clk_cfg[175 - 16 * i -: 16]});
      chk("read resp", {30'h0, CSDB_RESP_OKAY}, {30'h0, rsp});
    end
    chk("divider pair", 32'h0101, {16'h0, clk_cfg.codec_axi});
    chk("card source", 32'h2, {30'h0, clk_cfg.sdgpu.second_card_source});
    $display("test reset done");
  endtask

  task automatic t_mask();
    logic [15:0] e;
    for (int i = 0; i < 11; i++)
      for (int j = 0; j < 4; j++)
      begin
        e = (j == 3) ? 16'h0 : ((j == 2) ? (RW_EXP[i] & 16'hFF0F) : RW_EXP[i]);
        wr(12'h0C4 + 12'(i * 4), WD[j], rsp);
        rd(12'h0C4 + 12'(i * 4), dat, rsp);
        chk("masked write", {16'h0, e}, dat);
      end
    $display("test mask done");
  endtask

  task automatic t_codes();
    logic [1:0] codes [3] = '{2'b00, 2'b01, 2'b11};
    for (int c = 0; c < 3; c++)
    begin
      wr(12'h0C8, {16'h0003, 14'h0, codes[c]}, rsp);
      chk("ddr ratio", {30'h0, codes[c]}, {30'h0, clk_cfg.cammem.mem_phy_ratio});
    end
    for (int g = 0; g < 4; g++)
    begin
      wr(12'h0E8, {16'h00C0, 8'h00, 2'(g), 6'h00}, rsp);
      chk("gpu source", 32'(g), {30'h0, clk_cfg.sdgpu.gpu_source});
    end
    wr(12'h0C8, 32'h80048004, rsp);
    chk("cam out ref", 32'h1, {31'h0, clk_cfg.cammem.cam_out_ref24});
    chk("ddr source", 32'h1, {31'h0, clk_cfg.cammem.mem_source});
    wr(12'h0D4, 32'h00180010, rsp);
    chk("cam invert", 32'h1, {31'h0, clk_cfg.disp1.cam_in_invert});
    chk("isp invert", 32'h0, {31'h0, clk_cfg.disp1.isp_in_invert});
    // Low data byte with each mask byte: only the matching pair may write
    s_axi_wstrb <= 4'h5;
    wr(12'h0C4, 32'hFFFFFFFF, rsp);
    chk("strobe pair", 32'h00FF, {16'h0, clk_cfg.serial});
    s_axi_wstrb <= 4'h9;
    wr(12'h0C4, 32'hFFFFFFFF, rsp);
    chk("strobe split", 32'h00FF, {16'h0, clk_cfg.serial});
    s_axi_wstrb <= 4'hF;
    $display("test codes done");
  endtask

  task automatic t_unmapped();
    snap = clk_cfg;
    wr(12'h0C0, 32'hFFFFFFFF, rsp);
    chk("low hole resp", {30'h0, CSDB_RESP_SLVERR}, {30'h0, rsp});
    wr(12'h0F0, 32'hFFFFFFFF, rsp);
    chk("high hole resp", {30'h0, CSDB_RESP_SLVERR}, {30'h0, rsp});
    rd(12'h0F0, dat, rsp);
    chk("hole read resp", {30'h0, CSDB_RESP_SLVERR}, {30'h0, rsp});
    chk("hole read data", 32'h0, dat);
    for (int i = 0; i < 11; i++)
      chk("cfg kept", {16'h0, snap[175 - 16 * i -: 16]}, {16'h0, clk_cfg[175 - 16 * i -: 16]});
    $display("test unmapped done");
  endtask

  initial
  begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_mask();
    t_codes();
    t_unmapped();
    summarize();
  end
endmodule // csdb_bank_tb_top
